// File: core/rpu_pkg.sv
// Functional notes
// - Eight entries, each a match-address word followed by a replacement word.
// - Writing address then replacement word sets that entry's active flag automatically.
// - All eight addresses compared in parallel; hit swaps ROM word for replacement.
// - Among several matching active entries the highest-numbered one wins.
// - A one written to disable-strobe bit x clears active flag x only.
// - A one written to enable-strobe bit x sets active flag x again.
// - Registers reached over AHB on the bus clock; reprogram after power-up.
// - Register set occupies AHB window 0x40008400 to 0x400087FF.
package rpu_pkg;
	localparam int          NUM_ENTRIES   = 8;
	localparam int          IDX_W         = 3;
	localparam int          WORD_W        = 32;
	localparam int          OFF_W         = 10;
	localparam int          IDX_LSB       = 3;
	localparam int          DATA_SEL_BIT  = 2;
	localparam int          TRANS_BIT     = 1;
	localparam logic [31:0] WINDOW_FIRST  = 32'h4000_8400;
	localparam logic [31:0] WINDOW_LAST   = 32'h4000_87FF;
	localparam logic [9:0]  ENTRY_END     = 10'h040;
	localparam logic [9:0]  OFF_FLAGS     = 10'h040;
	localparam logic [9:0]  OFF_DISABLE   = 10'h044;
	localparam logic [9:0]  OFF_ENABLE    = 10'h048;
	localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
	localparam logic [7:0]  FLAGS_RESET   = 8'h00;
	localparam logic [23:0] FLAGS_PAD     = 24'h00_0000;
	localparam logic        HRESP_OKAY    = 1'h0;
endpackage

// File: core/rpu_entry.sv
`timescale 1ns/100ps
module rpu_entry (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        addrWrite,
	input  wire logic        dataWrite,
	input  wire logic        disableHit,
	input  wire logic        enableHit,
	input  wire logic [31:0] wrData,
	output logic [31:0]      matchAddress,
	output logic [31:0]      replaceWord,
	output logic             active,
	output logic             activeNext
);
	logic [31:0] addr_ff;
	logic [31:0] word_ff;
	logic        pending_ff;
	logic        active_ff;
	logic [31:0] nxt_addr;
	logic [31:0] nxt_word;
	logic        nxt_pending;
	logic        nxt_active;

	// Next state of one address/replacement pair
	always_comb begin
		nxt_addr    = addrWrite ? wrData : addr_ff;
		nxt_word    = dataWrite ? wrData : word_ff;
		nxt_pending = pending_ff;
		nxt_active  = active_ff;
		if (addrWrite) begin
			// A half-rewritten pair must not patch with a stale word
			nxt_pending = 1'h1;
			nxt_active  = 1'h0;
		end else if (dataWrite) begin
			nxt_pending = 1'h0;
			if (pending_ff) begin
				nxt_active = 1'h1;
			end
		end else if (enableHit) begin
			nxt_active = 1'h1;
		end else if (disableHit) begin
			nxt_active = 1'h0;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			addr_ff    <= rpu_pkg::WORD_RESET;
			word_ff    <= rpu_pkg::WORD_RESET;
			pending_ff <= 1'h0;
			active_ff  <= 1'h0;
		end else begin
			addr_ff    <= nxt_addr;
			word_ff    <= nxt_word;
			pending_ff <= nxt_pending;
			active_ff  <= nxt_active;
		end
	end

	assign matchAddress = addr_ff;
	assign replaceWord  = word_ff;
	assign active       = active_ff;
	assign activeNext   = nxt_active;
endmodule

// File: core/rpu_match.sv
`timescale 1ns/100ps
module rpu_match (
	input  wire logic [31:0]      address,
	input  wire logic [7:0][31:0] matchAddresses,
	input  wire logic [7:0]       activeFlags,
	output logic [7:0]            hitVector,
	output logic                  hit,
	output logic [2:0]            winIdx
);
	// Octal comparator, all entries at once
	genvar g;
	generate
		for (g = 0; g < rpu_pkg::NUM_ENTRIES; g++) begin : gCmp
			assign hitVector[g] = activeFlags[g] && (matchAddresses[g] == address);
		end
	endgenerate

	// Ascending scan so the last matching entry overrides earlier ones
	always_comb begin
		hit    = 1'h0;
		winIdx = 3'h0;
		for (int i = 0; i < rpu_pkg::NUM_ENTRIES; i++) begin
			if (hitVector[i]) begin
				hit    = 1'h1;
				winIdx = i[2:0];
			end
		end
	end
endmodule

// File: core/rom_patch_unit.sv
`timescale 1ns/100ps
module rom_patch_unit (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        romSel,
	input  wire logic [31:0] romRdata,
	output logic [31:0]      patchRdata
);
	logic [7:0][31:0] entryAddr;
	logic [7:0][31:0] entryWord;
	logic [7:0]       activeFlags;
	logic [7:0]       activeNext;
	logic [7:0]       addrWrVec;
	logic [7:0]       dataWrVec;
	logic [7:0]       disableVec;
	logic [7:0]       enableVec;
	logic [7:0]       hitVector;
	logic             matchHit;
	logic [2:0]       matchIdx;
	logic             regPhase;
	logic             romPhase;
	logic             inWindow;
	logic [9:0]       rdOff;
	logic [31:0]      rdValue;
	logic             wrEntry;
	logic [2:0]       wrIdx;
	logic             wrPend_ff;
	logic [9:0]       wrOff_ff;
	logic [31:0]      hrdata_ff;
	logic             hreadyout_ff;
	logic             hit_ff;
	logic [31:0]      word_ff;
	logic             nxt_wrPend;
	logic [9:0]       nxt_wrOff;
	logic [31:0]      nxt_hrdata;
	logic             nxt_hit;
	logic [31:0]      nxt_word;

	// Address-phase qualifiers; hsel covers the whole patch window
	assign regPhase = hsel && htrans[rpu_pkg::TRANS_BIT] && hready;
	assign romPhase = romSel && htrans[rpu_pkg::TRANS_BIT] && hready;
	assign inWindow = (haddr >= rpu_pkg::WINDOW_FIRST) && (haddr <= rpu_pkg::WINDOW_LAST);
	assign rdOff    = haddr[rpu_pkg::OFF_W-1:0];

	// Data-phase write decode into per-entry strobes
	assign wrEntry = wrPend_ff && (wrOff_ff < rpu_pkg::ENTRY_END);
	assign wrIdx   = wrOff_ff[rpu_pkg::IDX_LSB +: rpu_pkg::IDX_W];
	always_comb begin
		addrWrVec  = rpu_pkg::FLAGS_RESET;
		dataWrVec  = rpu_pkg::FLAGS_RESET;
		disableVec = rpu_pkg::FLAGS_RESET;
		enableVec  = rpu_pkg::FLAGS_RESET;
		if (wrEntry) begin
			// Even word of a pair is the address, odd word the replacement
			if (wrOff_ff[rpu_pkg::DATA_SEL_BIT]) begin
				dataWrVec[wrIdx] = 1'h1;
			end else begin
				addrWrVec[wrIdx] = 1'h1;
			end
		end
		if (wrPend_ff && (wrOff_ff == rpu_pkg::OFF_DISABLE)) begin
			disableVec = hwdata[7:0];
		end
		if (wrPend_ff && (wrOff_ff == rpu_pkg::OFF_ENABLE)) begin
			enableVec = hwdata[7:0];
		end
	end

	// Eight identical register pairs
	genvar g;
	generate
		for (g = 0; g < rpu_pkg::NUM_ENTRIES; g++) begin : gEntry
			rpu_entry uEntry (
				.clock        (clock),
				.reset        (reset),
				.addrWrite    (addrWrVec[g]),
				.dataWrite    (dataWrVec[g]),
				.disableHit   (disableVec[g]),
				.enableHit    (enableVec[g]),
				.wrData       (hwdata),
				.matchAddress (entryAddr[g]),
				.replaceWord  (entryWord[g]),
				.active       (activeFlags[g]),
				.activeNext   (activeNext[g])
			);
		end
	endgenerate

	rpu_match uMatch (
		.address        (haddr),
		.matchAddresses (entryAddr),
		.activeFlags    (activeFlags),
		.hitVector      (hitVector),
		.hit            (matchHit),
		.winIdx         (matchIdx)
	);

	// Read mux; forwards a write still in its data phase so back-to-back is safe
	always_comb begin
		rdValue = rpu_pkg::WORD_RESET;
		if (inWindow && (rdOff < rpu_pkg::ENTRY_END)) begin
			if (wrPend_ff && (wrOff_ff == rdOff)) begin
				rdValue = hwdata;
			end else if (rdOff[rpu_pkg::DATA_SEL_BIT]) begin
				rdValue = entryWord[rdOff[rpu_pkg::IDX_LSB +: rpu_pkg::IDX_W]];
			end else begin
				rdValue = entryAddr[rdOff[rpu_pkg::IDX_LSB +: rpu_pkg::IDX_W]];
			end
		end else if (inWindow && (rdOff == rpu_pkg::OFF_FLAGS)) begin
			rdValue = {rpu_pkg::FLAGS_PAD, activeNext};
		end
	end

	// Bus slave next state; strobe registers are write-only and read zero
	always_comb begin
		nxt_wrPend = regPhase && hwrite && inWindow;
		nxt_wrOff  = nxt_wrPend ? rdOff : wrOff_ff;
		nxt_hrdata = hrdata_ff;
		if (regPhase && !hwrite) begin
			nxt_hrdata = rdValue;
		end
	end

	// ROM path: match decided in address phase, applied in data phase
	always_comb begin
		nxt_hit  = hit_ff;
		nxt_word = word_ff;
		if (romPhase) begin
			nxt_hit  = matchHit;
			nxt_word = entryWord[matchIdx];
		end else if (hready) begin
			nxt_hit = 1'h0;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wrPend_ff    <= 1'h0;
			wrOff_ff     <= rpu_pkg::OFF_FLAGS;
			hrdata_ff    <= rpu_pkg::WORD_RESET;
			hreadyout_ff <= 1'h1;
			hit_ff       <= 1'h0;
			word_ff      <= rpu_pkg::WORD_RESET;
		end else begin
			wrPend_ff    <= nxt_wrPend;
			wrOff_ff     <= nxt_wrOff;
			hrdata_ff    <= nxt_hrdata;
			hreadyout_ff <= 1'h1;
			hit_ff       <= nxt_hit;
			word_ff      <= nxt_word;
		end
	end

	assign hreadyout  = hreadyout_ff;
	assign hresp      = rpu_pkg::HRESP_OKAY;
	assign hrdata     = hrdata_ff;
	// Mux stays combinational on the ROM word: a flop here would cost a wait state
	assign patchRdata = hit_ff ? word_ff : romRdata;

	// Checks
	default clocking cbPatch @(posedge clock); endclocking
	default disable iff (reset);

	a_flags_after_reset: assert property ($fell(reset) |-> activeFlags == rpu_pkg::FLAGS_RESET)
		else $error("active flags not clear after reset");
	a_addr_slot_store: assert property (addrWrVec[0] |=> entryAddr[0] == $past(hwdata))
		else $error("entry 0 address not stored");
	// Address word lands, a gap cycle, then the replacement word lands
	a_pair_sets_active: assert property (
		addrWrVec[0] ##1 !(|addrWrVec) ##1
		(dataWrVec[0] && !addrWrVec[0]) |=> activeFlags[0])
		else $error("pair write did not set active flag");
	a_disable_clears: assert property (
		(disableVec != rpu_pkg::FLAGS_RESET) && !(|addrWrVec) && !(|dataWrVec)
		|=> (activeFlags & $past(disableVec)) == rpu_pkg::FLAGS_RESET)
		else $error("disable strobe did not clear flag");
	a_enable_sets: assert property (
		(enableVec != rpu_pkg::FLAGS_RESET) |=> (activeFlags & $past(enableVec)) == $past(enableVec))
		else $error("enable strobe did not set flag");
	a_hit_replaces: assert property (
		romPhase && matchHit |=> patchRdata == $past(entryWord[matchIdx]))
		else $error("hit did not replace ROM word");
	a_priority_high: assert property (
		romPhase && matchHit |-> (hitVector >> matchIdx) == 8'h01)
		else $error("lower entry won over higher match");
	a_miss_passes: assert property (romPhase && !matchHit |=> patchRdata == romRdata)
		else $error("miss altered ROM data");
	a_no_wait: assert property (hreadyout && hresp == rpu_pkg::HRESP_OKAY)
		else $error("slave inserted wait or error");
	a_outside_zero: assert property (regPhase && !hwrite && !inWindow |=> hrdata == rpu_pkg::WORD_RESET)
		else $error("outside window read not zero");

	c_patch_hit: cover property (romPhase && matchHit);
	c_two_match: cover property (romPhase && $countones(hitVector) > 1);
	c_disable_enable: cover property ((disableVec != 8'h00) ##[1:20] (enableVec != 8'h00));
endmodule

// File: dv/rpu_rom_model.sv
`timescale 1ns/100ps
module rpu_rom_model (
	input  wire logic        clock,
	input  wire logic        romSel,
	input  wire logic [1:0]  htrans,
	input  wire logic        hready,
	input  wire logic [31:0] haddr,
	output logic [31:0]      romRdata
);
	logic [31:0] word_ff;

	// ROM word is the inverted address; between data phases the bus
	// toggles so a stale word can never pass for a good one
	always_ff @(posedge clock) begin
		if (romSel && htrans[1] && hready)
			word_ff <= ~haddr;
		else
			word_ff <= ~word_ff;
	end
	assign romRdata = word_ff;
endmodule

// File: dv/rom_patch_unit_tb.sv
`timescale 1ns/100ps
module rom_patch_unit_tb;
	localparam logic [31:0] BASE  = rpu_pkg::WINDOW_FIRST;
	localparam logic [31:0] FLAGS = BASE + {22'h0, rpu_pkg::OFF_FLAGS};
	localparam logic [31:0] DIS   = BASE + {22'h0, rpu_pkg::OFF_DISABLE};
	localparam logic [31:0] ENA   = BASE + {22'h0, rpu_pkg::OFF_ENABLE};
	logic        clock, reset, hsel, hwrite, hready, hreadyout, hresp, romSel;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, romRdata, patchRdata, got;
	int          mismatches, samples_checked;
	// Rows: match address beside the word a read there should return
	logic [31:0] rowAddr [8] = '{32'h0000_0100, 32'h0000_0204, 32'h0000_0308,
		32'h0000_040C, 32'h0000_0510, 32'h0000_0614, 32'h0000_0718, 32'h0000_081C};
	logic [31:0] rowWord [8] = '{32'hA000_0001, 32'hB000_0002, 32'hC000_0003,
		32'hD000_0004, 32'hE000_0005, 32'hF000_0006, 32'h1000_0007, 32'h2000_0008};

	rom_patch_unit rom_patch_unit_inst (.clock, .reset, .hsel, .haddr, .htrans, .hwrite,
		.hready, .hwdata, .hreadyout, .hresp, .hrdata, .romSel, .romRdata, .patchRdata);
	rpu_rom_model rpu_rom_model_inst (.clock, .romSel, .htrans, .hready, .haddr, .romRdata);

	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end

	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask

	// Write: address phase, then data phase on the following cycle
	task wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel   <= 1'h1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= 1'h1;
		@(posedge clock);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
	endtask

	// Register read or ROM fetch; answer sampled once the data phase settles
	task acc(input logic isRom, input logic [31:0] a, output logic [31:0] d);
		@(posedge clock);
		hsel   <= !isRom;
		romSel <= isRom;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= 1'h0;
		@(posedge clock);
		hsel   <= 1'h0;
		romSel <= 1'h0;
		htrans <= 2'h0;
		#1 d = isRom ? patchRdata : hrdata;
	endtask

	task results;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Watchdog well beyond the fewer than 200 cycles the run needs
	initial begin
		#50000;
		mismatches++;
		results();
	end

	initial begin
		reset = 1'h1;
		hsel = 1'h0;
		romSel = 1'h0;
		hwrite = 1'h0;
		hready = 1'h1;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (20) @(posedge clock);
		reset <= 1'h0;
		// Program entries one by one; each hits and arms its own flag
		for (int i = 0; i < 8; i++) begin
			wr(BASE + 32'(i) * 32'h8, rowAddr[i]);
			wr(BASE + 32'(i) * 32'h8 + 32'h4, rowWord[i]);
			acc(1'h1, rowAddr[i], got);
			chk(got, rowWord[i], "patched word");
			acc(1'h0, FLAGS, got);
			chk(got, 32'((32'h1 << (i + 1)) - 32'h1), "active flags");
			acc(1'h0, BASE + 32'(i) * 32'h8, got);
			chk(got, rowAddr[i], "match address readback");
		end
		// Entry 7 aimed at the same address as entry 2 must win
		wr(BASE + 32'h38, rowAddr[2]);
		wr(BASE + 32'h3C, 32'hCAFE_F00D);
		acc(1'h1, rowAddr[2], got);
		chk(got, 32'hCAFE_F00D, "highest entry wins");
		wr(DIS, 32'h80);
		acc(1'h1, rowAddr[2], got);
		chk(got, rowWord[2], "lower entry after disable");
		wr(DIS, 32'h04);
		acc(1'h1, rowAddr[2], got);
		chk(got, ~rowAddr[2], "miss passes rom word");
		acc(1'h0, FLAGS, got);
		chk(got, 32'h7B, "flags after disable");
		wr(ENA, 32'h80);
		acc(1'h1, rowAddr[2], got);
		chk(got, 32'hCAFE_F00D, "re-enabled entry");
		// ROM wait state after a hit: the replacement must stay selected
		@(posedge clock);
		romSel <= 1'h1;
		haddr  <= rowAddr[2];
		htrans <= 2'h2;
		@(posedge clock);
		romSel <= 1'h0;
		htrans <= 2'h0;
		hready <= 1'h0;
		@(posedge clock);
		#1 chk(patchRdata, 32'hCAFE_F00D, "patch held in wait");
		@(posedge clock);
		hready <= 1'h1;
		acc(1'h0, FLAGS, got);
		chk(got, 32'hFB, "flags after enable");
		// Window edges, unmapped and write-only places
		wr(32'h4000_8800, 32'hDEAD_BEEF);
		acc(1'h0, BASE, got);
		chk(got, rowAddr[0], "write past window ignored");
		acc(1'h0, BASE + 32'h100, got);
		chk(got, 32'h0, "unmapped reads zero");
		acc(1'h0, DIS, got);
		chk(got, 32'h0, "write-only reads zero");
		chk({31'h0, hreadyout}, 32'h1, "no wait state");
		chk({31'h0, hresp}, 32'h0, "okay response");
		// Reset in mid-run drops every patch
		@(posedge clock);
		reset <= 1'h1;
		repeat (3) @(posedge clock);
		reset <= 1'h0;
		acc(1'h0, FLAGS, got);
		chk(got, 32'h0, "flags after reset");
		acc(1'h1, rowAddr[5], got);
		chk(got, ~rowAddr[5], "no patch after reset");
		// Replacement word alone, without its address first, stays idle
		wr(BASE + 32'h4, 32'h1234_5678);
		acc(1'h0, FLAGS, got);
		chk(got, 32'h0, "lone data write");
		results();
	end
endmodule
